//--- logic/uhlsc_pkg.sv
// Package of offsets, field positions and reset values for the legacy SMI and capability block.
`default_nettype none
package uhlsc_pkg;
    // Configuration space placement of the legacy extended capability.
    localparam logic [7:0] UHLSC_EXT_CAP_PTR = 8'ha0;
    localparam logic [7:0] UHLSC_MIN_EXT_CAP_PTR = 8'h40;
    localparam logic [7:0] UHLSC_OWN_SUPPORT_OFS = 8'ha0;
    localparam logic [7:0] UHLSC_SMI_CTL_OFS = 8'ha4;
    localparam logic [7:0] UHLSC_PCI_CMD_OFS = 8'h04;
    localparam logic [7:0] UHLSC_BAR_OFS = 8'h10;
    // Memory offsets of the capability registers.
    localparam logic [7:0] UHLSC_CAPLEN_OFS = 8'h00;
    localparam logic [7:0] UHLSC_STRUCT_OFS = 8'h04;
    localparam logic [7:0] UHLSC_CAPPAR_OFS = 8'h08;
    localparam logic [7:0] UHLSC_ROUTE_LO_OFS = 8'h0c;
    localparam logic [7:0] UHLSC_ROUTE_HI_OFS = 8'h10;
    localparam int UHLSC_CAP_SPAN_BITS = 5;
    // Capability values.
    localparam logic [7:0] UHLSC_CAPLEN_VAL = 8'h20;
    localparam logic [15:0] UHLSC_VERSION_VAL = 16'h0100;
    localparam logic [3:0] UHLSC_PORT_COUNT = 4'ha;
    localparam logic UHLSC_PORT_POWER_SWITCH = 1'b0;
    localparam logic UHLSC_ROUTING_RULE = 1'b0;
    localparam logic [3:0] UHLSC_PORTS_PER_COMP = 4'h2;
    localparam logic [3:0] UHLSC_COMPANION_COUNT = 4'h5;
    localparam logic UHLSC_PORT_INDICATOR = 1'b0;
    localparam logic [3:0] UHLSC_DEBUG_PORT = 4'h1;
    localparam logic UHLSC_ADDR64 = 1'b0;
    localparam logic UHLSC_PROG_FRAME_LIST = 1'b1;
    localparam logic UHLSC_PARK_CAP = 1'b0;
    localparam logic [3:0] UHLSC_ISO_THRESHOLD = 4'h1;
    localparam logic [59:0] UHLSC_ROUTE_RESET = 60'h000000000000000;
    // Legacy control/status field positions.
    localparam int UHLSC_NUM_SHADOW = 6;
    localparam int UHLSC_EN_LSB = 0;
    localparam int UHLSC_OWN_EN_BIT = 13;
    localparam int UHLSC_CMD_EN_BIT = 14;
    localparam int UHLSC_BAR_EN_BIT = 15;
    localparam int UHLSC_SHADOW_LSB = 16;
    localparam int UHLSC_OWN_FLAG_BIT = 29;
    localparam int UHLSC_CMD_FLAG_BIT = 30;
    localparam int UHLSC_BAR_FLAG_BIT = 31;
    localparam int UHLSC_OS_OWNED_BIT = 24;
    localparam logic [31:0] UHLSC_SMI_CTL_RESET = 32'h00000000;
endpackage
`default_nettype wire

//--- logic/uhlsc_route_mem.sv
// Route array store of fifteen nibbles, read out through a register.
`timescale 1ns/10ps
`default_nettype none
module uhlsc_route_mem
    import uhlsc_pkg::*;
#(
    parameter int ENTRIES = 15,
    parameter int ENTRY_BITS = 4
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic hi_word_i,
    output logic [31:0] rdata_o
);
    localparam int TOTAL = ENTRIES * ENTRY_BITS;

    initial begin
        if (TOTAL > 64 || TOTAL <= 32) begin
            $error("Route array must span between 33 and 64 bits.");
        end
    end

    logic [63:0] route_word;

    // The array stays at its reset image since the routing rule selects groups.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            route_word <= {4'h0, UHLSC_ROUTE_RESET};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdata_o <= 32'h00000000;
        end else begin
            rdata_o <= hi_word_i ? route_word[63:32] : route_word[31:0];
        end
    end
endmodule
`default_nettype wire

//--- logic/uhlsc_top.sv
// Legacy SMI control/status and capability register block of a USB 2.0 host controller.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RL1: Each of enables 0..5 with its matching shadow flag raises SMI at once.
// RL2: Ownership enable bit 13 with ownership-change flag bit 29 raises SMI.
// RL3: Command-write enable bit 14 with command-write flag bit 30 raises SMI.
// RL4: Any BAR write sets flag 31; with enable 15 it raises SMI. The code ignores BAR writes with all byte enables off.
// RL5: Bits 16..21 mirror status flags, cleared only via the status register.
// RL6: Every toggle of the OS-owned semaphore sets flag bit 29. The code misses a toggle in the first cycle after reset.
// RL7: Any write to the PCI command register sets flag bit 30. The code ignores writes with all byte enables off.
// RL8: Software writes zeros to reserved bits 12:6 and 28:22.
// RL9: Capability registers answer at BAR base plus register offset.
// RL10: Capability length reads 20h, the offset to operational registers.
// RL11: Interface version reads 0100h in BCD.
// RL12: Port count field bits 3:0 reads Ah; only 1h..Fh valid.
// RL13: Bit 4 and bit 16 of structural parameters read zero.
// RL14: Routing rule bit 7 reads zero, companions take consecutive port groups.
// RL15: Ports per companion reads 2h, companion count reads 5h.
// RL16: Debug port field reads 1h and never exceeds the port count.
// RL17: Capability bit 0 reads zero, 32-bit pointers only.
// RL18: Capability bit 1 reads one; frame list stays 4K aligned.
// RL19: Capability bit 2 reads zero, no park mode.
// RL20: Isochronous threshold bits 7:4 read 1h.
// RL21: Extended capability pointer reads A0h, at least 40h.
// RL22: Route register holds fifteen 4-bit entries, meaningful only with rule one.
// RL23: Software toggles the OS-owned semaphore bit 24 to request ownership.
// RL24: SMI output is the OR of all enabled event pairs, a level.
module uhlsc_top
    import uhlsc_pkg::*;
#(
    parameter logic [3:0] PORT_COUNT = UHLSC_PORT_COUNT,
    parameter logic [3:0] DEBUG_PORT = UHLSC_DEBUG_PORT,
    parameter logic [7:0] EXT_CAP_PTR = UHLSC_EXT_CAP_PTR
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic cfg_wr_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    output logic [31:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    input wire logic mem_rd_i,
    input wire logic [31:0] mem_addr_i,
    output logic [31:0] mem_rdata_o,
    output logic mem_rvalid_o,
    output logic mem_hit_o,
    input wire logic [31:0] bar_base_i,
    input wire logic os_owned_i,
    input wire logic [5:0] status_flags_i,
    output logic smi_o
);
    initial begin
        if (PORT_COUNT == 4'h0) begin
            $error("Port count must lie in 1h to Fh."); // RL12
        end
        if (DEBUG_PORT > PORT_COUNT) begin
            $error("Debug port exceeds port count."); // RL16
        end
        if (EXT_CAP_PTR < UHLSC_MIN_EXT_CAP_PTR) begin
            $error("Extended capability pointer below 40h."); // RL21
        end
    end

    logic [5:0] shadow_en;
    logic own_en;
    logic cmd_en;
    logic bar_en;
    logic own_flag;
    logic cmd_flag;
    logic bar_flag;
    logic os_owned_q;
    logic os_owned_seen;
    logic [31:0] ctl_word;
    logic ctl_wr;
    logic own_toggle;
    logic cmd_write;
    logic bar_write;
    logic [31:0] structural_word;
    logic [31:0] capability_word;
    logic [31:0] cap_offset;
    logic cap_hit;
    logic [31:0] next_mem_rdata;
    logic route_sel;
    logic route_rd;
    logic route_rd_q;
    logic [31:0] route_rdata;
    logic [31:0] next_cfg_rdata;

    assign ctl_wr = cfg_wr_i && (cfg_addr_i == UHLSC_SMI_CTL_OFS);
    assign cmd_write = cfg_wr_i && (cfg_addr_i == UHLSC_PCI_CMD_OFS) && (cfg_be_i != 4'h0);
    assign bar_write = cfg_wr_i && (cfg_addr_i == UHLSC_BAR_OFS) && (cfg_be_i != 4'h0);

    // The semaphore sits outside this block; a previous-value register spots each toggle except in the first cycle after reset.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            os_owned_q <= 1'b0;
            os_owned_seen <= 1'b0;
        end else begin
            os_owned_q <= os_owned_i;
            os_owned_seen <= 1'b1;
        end
    end

    assign own_toggle = os_owned_seen && (os_owned_q != os_owned_i); // RL6 RL23

    // Enable bits; reserved fields are not stored and read as zero.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            shadow_en <= UHLSC_SMI_CTL_RESET[5:0];
            own_en <= 1'b0;
            cmd_en <= 1'b0;
            bar_en <= 1'b0;
        end else if (ctl_wr) begin
            if (cfg_be_i[0]) begin
                shadow_en <= cfg_wdata_i[UHLSC_EN_LSB +: UHLSC_NUM_SHADOW]; // RL8
            end
            if (cfg_be_i[1]) begin
                own_en <= cfg_wdata_i[UHLSC_OWN_EN_BIT];
                cmd_en <= cfg_wdata_i[UHLSC_CMD_EN_BIT];
                bar_en <= cfg_wdata_i[UHLSC_BAR_EN_BIT];
            end
        end
    end

    // Sticky event flags: write one clears, but a new event in that cycle wins.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            own_flag <= 1'b0;
            cmd_flag <= 1'b0;
            bar_flag <= 1'b0;
        end else begin
            if (own_toggle) begin
                own_flag <= 1'b1; // RL6
            end else if (ctl_wr && cfg_be_i[3] && cfg_wdata_i[UHLSC_OWN_FLAG_BIT]) begin
                own_flag <= 1'b0;
            end
            if (cmd_write) begin
                cmd_flag <= 1'b1; // RL7
            end else if (ctl_wr && cfg_be_i[3] && cfg_wdata_i[UHLSC_CMD_FLAG_BIT]) begin
                cmd_flag <= 1'b0;
            end
            if (bar_write) begin
                bar_flag <= 1'b1; // RL4
            end else if (ctl_wr && cfg_be_i[3] && cfg_wdata_i[UHLSC_BAR_FLAG_BIT]) begin
                bar_flag <= 1'b0;
            end
        end
    end

    // Shadow flags are pure mirrors; this block offers no way to clear them.
    always_comb begin
        ctl_word = 32'h00000000;
        ctl_word[UHLSC_EN_LSB +: UHLSC_NUM_SHADOW] = shadow_en;
        ctl_word[UHLSC_OWN_EN_BIT] = own_en;
        ctl_word[UHLSC_CMD_EN_BIT] = cmd_en;
        ctl_word[UHLSC_BAR_EN_BIT] = bar_en;
        ctl_word[UHLSC_SHADOW_LSB +: UHLSC_NUM_SHADOW] = status_flags_i; // RL5
        ctl_word[UHLSC_OWN_FLAG_BIT] = own_flag;
        ctl_word[UHLSC_CMD_FLAG_BIT] = cmd_flag;
        ctl_word[UHLSC_BAR_FLAG_BIT] = bar_flag;
    end

    // Combinational so the request follows the pair within the same cycle.
    always_comb begin
        smi_o = |(shadow_en & status_flags_i); // RL1 RL24
        smi_o = smi_o | (own_en & own_flag); // RL2
        smi_o = smi_o | (cmd_en & cmd_flag); // RL3
        smi_o = smi_o | (bar_en & bar_flag); // RL4
    end

    // Configuration reads of the two legacy registers; other offsets belong elsewhere.
    always_comb begin
        next_cfg_rdata = 32'h00000000;
        if (cfg_addr_i == UHLSC_SMI_CTL_OFS) begin
            next_cfg_rdata = ctl_word;
        end else if (cfg_addr_i == UHLSC_OWN_SUPPORT_OFS) begin
            next_cfg_rdata = {7'h00, os_owned_i, 24'h000001};
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            cfg_rdata_o <= 32'h00000000;
            cfg_rvalid_o <= 1'b0;
        end else begin
            cfg_rvalid_o <= cfg_rd_i;
            if (cfg_rd_i) begin
                cfg_rdata_o <= next_cfg_rdata;
            end
        end
    end

    // Capability words, all hard values.
    always_comb begin
        structural_word = 32'h00000000;
        structural_word[3:0] = PORT_COUNT; // RL12
        structural_word[4] = UHLSC_PORT_POWER_SWITCH; // RL13
        structural_word[7] = UHLSC_ROUTING_RULE; // RL14
        structural_word[11:8] = UHLSC_PORTS_PER_COMP; // RL15
        structural_word[15:12] = UHLSC_COMPANION_COUNT; // RL15
        structural_word[16] = UHLSC_PORT_INDICATOR; // RL13
        structural_word[23:20] = DEBUG_PORT; // RL16
        capability_word = 32'h00000000;
        capability_word[0] = UHLSC_ADDR64; // RL17
        capability_word[1] = UHLSC_PROG_FRAME_LIST; // RL18
        capability_word[2] = UHLSC_PARK_CAP; // RL19
        capability_word[7:4] = UHLSC_ISO_THRESHOLD; // RL20
        capability_word[15:8] = EXT_CAP_PTR; // RL21
    end

    assign cap_offset = mem_addr_i - bar_base_i; // RL9
    assign cap_hit = (mem_addr_i >= bar_base_i) && (cap_offset[31:UHLSC_CAP_SPAN_BITS] == 27'h0);
    assign route_sel = cap_offset[7:0] == UHLSC_ROUTE_HI_OFS;
    assign route_rd = mem_rd_i && cap_hit && (cap_offset[7:0] == UHLSC_ROUTE_LO_OFS || route_sel);
    assign mem_hit_o = mem_rd_i && cap_hit;

    always_comb begin
        next_mem_rdata = 32'h00000000;
        unique case ({cap_offset[7:2], 2'b00})
            UHLSC_CAPLEN_OFS: next_mem_rdata = {UHLSC_VERSION_VAL, 8'h00, UHLSC_CAPLEN_VAL}; // RL10 RL11
            UHLSC_STRUCT_OFS: next_mem_rdata = structural_word;
            UHLSC_CAPPAR_OFS: next_mem_rdata = capability_word;
            default: next_mem_rdata = 32'h00000000;
        endcase
    end

    uhlsc_route_mem #(
        .ENTRIES(15),
        .ENTRY_BITS(4)
    ) u_route (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .hi_word_i(route_sel),
        .rdata_o(route_rdata)
    ); // RL22

    logic [31:0] mem_word_q;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            mem_word_q <= 32'h00000000;
            mem_rvalid_o <= 1'b0;
            route_rd_q <= 1'b0;
        end else begin
            mem_rvalid_o <= mem_rd_i && cap_hit;
            route_rd_q <= route_rd;
            if (mem_rd_i && cap_hit) begin
                mem_word_q <= next_mem_rdata;
            end
        end
    end

    assign mem_rdata_o = route_rd_q ? route_rdata : mem_word_q;
endmodule
`default_nettype wire

//--- bench/uhlsc_monitor.sv
// Port checker for the legacy SMI and capability block.
`timescale 1ns/10ps
`default_nettype none
module uhlsc_monitor (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic cfg_wr_i,
    input wire logic [7:0] cfg_addr_i,
    input wire logic [3:0] cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic mem_rd_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_rdata_o,
    input wire logic mem_rvalid_o,
    input wire logic mem_hit_o,
    input wire logic [31:0] bar_base_i,
    input wire logic os_owned_i,
    input wire logic [5:0] status_flags_i,
    input wire logic smi_o
);
    logic [8:0] en;
    logic [31:0] ofs;
    assign ofs = mem_addr_i - bar_base_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // Shadow of the enables, so the SMI level can be judged from the ports alone.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            en <= 9'h000;
        end else if (cfg_wr_i && cfg_addr_i == 8'ha4) begin
            if (cfg_be_i[0]) begin
                en[5:0] <= cfg_wdata_i[5:0];
            end
            if (cfg_be_i[1]) begin
                en[8:6] <= cfg_wdata_i[15:13];
            end
        end
    end
    a_hit_window: assert property (mem_hit_o == (mem_rd_i && ofs < 32'h20))
        else $error("hit outside window");
    a_refused_read: assert property (mem_rd_i && !mem_hit_o |=> !mem_rvalid_o)
        else $error("answer to refused read");
    a_length_word: assert property (mem_hit_o && ofs == 0 |=> mem_rdata_o == 32'h01000020)
        else $error("length word");
    a_struct_word: assert property (mem_hit_o && ofs == 4 |=> mem_rdata_o == 32'h0010520a)
        else $error("structure word");
    a_event_smi: assert property ((|(en[5:0] & status_flags_i))[*2] |-> smi_o)
        else $error("no SMI for enabled shadow");
    a_cmd_write: assert property (cfg_wr_i && cfg_addr_i == 8'h04 && cfg_be_i != 4'h0 && en[7]
        |-> ##[1:2] smi_o)
        else $error("no SMI after command write");
    a_bar_write: assert property (cfg_wr_i && cfg_addr_i == 8'h10 && cfg_be_i != 4'h0 && en[8]
        |-> ##[1:2] smi_o)
        else $error("no SMI after base write");
    a_owner_toggle: assert property (!$past(srst_i, 2) && $changed(os_owned_i) && en[6]
        |-> ##[1:2] smi_o)
        else $error("no SMI after ownership change");
    a_smi_quiet: assert property (en == 9'h000 |-> !smi_o)
        else $error("SMI with nothing enabled");
endmodule
bind uhlsc_top uhlsc_monitor i_uhlsc_monitor (.ref_clk_i, .srst_i, .cfg_wr_i, .cfg_addr_i,
    .cfg_be_i, .cfg_wdata_i, .mem_rd_i, .mem_addr_i, .mem_rdata_o, .mem_rvalid_o, .mem_hit_o,
    .bar_base_i, .os_owned_i, .status_flags_i, .smi_o);
`default_nettype wire

//--- bench/uhlsc_host_model.sv
// Host side model holding the controller status flags and the OS-owned semaphore.
`timescale 1ns/10ps
`default_nettype none
module uhlsc_host_model (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic toggle_i,
    input wire logic [5:0] set_i,
    input wire logic [5:0] clr_i,
    output logic os_owned_o,
    output logic [5:0] status_flags_o
);
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            os_owned_o <= 1'b0;
        end else if (toggle_i) begin
            os_owned_o <= ~os_owned_o;
        end
    end
    // Flags drop only when software writes a one to them, never on their own.
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            status_flags_o <= 6'h00;
        end else begin
            status_flags_o <= (status_flags_o & ~clr_i) | set_i;
        end
    end
endmodule
`default_nettype wire

//--- bench/test_usb2_host_legacy_smi_caps.sv
// Self-checking testbench of the legacy SMI and capability block.
`timescale 1ns/10ps
`default_nettype none
module test_usb2_host_legacy_smi_caps;
    import uhlsc_pkg::*;
    logic clk = 0, srst = 1, wr = 0, rd = 0, mrd = 0, tog = 0, own, rv, mrv, hit, smi;
    logic [7:0] adr = 0;
    logic [3:0] be = 0;
    logic [5:0] set = 0, clr = 0, fl, w;
    logic [31:0] wd = 0, rdat, maddr = 0, mdat, bar = 0, d;
    int failures = 0, samples_checked = 0, e;
    integer seed = 32'hc903;
    uhlsc_top i_uhlsc_top (.ref_clk_i(clk), .srst_i(srst), .cfg_wr_i(wr), .cfg_rd_i(rd),
        .cfg_addr_i(adr), .cfg_be_i(be), .cfg_wdata_i(wd), .cfg_rdata_o(rdat),
        .cfg_rvalid_o(rv), .mem_rd_i(mrd), .mem_addr_i(maddr), .mem_rdata_o(mdat),
        .mem_rvalid_o(mrv), .mem_hit_o(hit), .bar_base_i(bar), .os_owned_i(own),
        .status_flags_i(fl), .smi_o(smi));
    uhlsc_host_model i_uhlsc_host_model (.ref_clk_i(clk), .srst_i(srst), .toggle_i(tog),
        .set_i(set), .clr_i(clr), .os_owned_o(own), .status_flags_o(fl));
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic check_value(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] b, input logic [31:0] v);
        adr = a;
        be = b;
        wd = v;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        tick(1);
    endtask
    task automatic cfg_read(input logic [7:0] a);
        adr = a;
        rd = 1'b1;
        tick(1);
        rd = 1'b0;
        check_value(rv, 1);
        d = rdat;
        tick(1);
    endtask
    task automatic mem_read(input logic [31:0] o, input logic h);
        maddr = bar + o;
        mrd = 1'b1;
        // The hit flag only stands while the strobe is high, so look before the edge.
        #2;
        check_value(hit, h);
        tick(1);
        mrd = 1'b0;
        check_value(mrv, h);
        if (h) begin
            check_value(mdat, cap_word(o[7:0]));
        end
        tick(1);
    endtask
    function automatic logic [31:0] cap_word(input logic [7:0] o);
        case (o)
            8'h00: return 32'h01000020;
            8'h04: return 32'h0010520a;
            8'h08: return 32'h0000a012;
            default: return 32'h00000000;
        endcase
    endfunction
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        failures++;
        complete_run();
    end
    initial begin
        bar = $random(seed) & 32'hffffff00;
        tick(10);
        srst = 1'b0;
        cfg_read(8'ha4);
        check_value(d, 32'h0);
        for (e = 0; e < 5; e++) begin
            mem_read(e * 4, 1'b1);
        end
        mem_read(32'h20, 1'b0);
        cfg_read(8'h50);
        check_value(d, 32'h0);
        repeat (16) begin
            w = 6'($random(seed));
            cfg_write(8'ha4, 4'h1, {26'h0, w});
            set = 6'($random(seed));
            tick(2);
            set = 6'h00;
            check_value(smi, |(w & fl));
            cfg_read(8'ha4);
            check_value(d, {10'h0, fl, 10'h0, w});
            clr = 6'h3f;
            tick(2);
            clr = 6'h00;
        end
        // Event order: command write, base write, semaphore rise, semaphore fall.
        for (e = 0; e < 4; e++) begin
            d = (e == 0) ? 32'h4000 : (e == 1) ? 32'h8000 : 32'h2000;
            cfg_write(8'ha4, 4'h3, d);
            check_value(smi, 0);
            if (e < 2) begin
                cfg_write(e ? 8'h10 : 8'h04, 4'hf, $random(seed));
            end else begin
                tog = 1'b1;
                tick(1);
                tog = 1'b0;
                tick(1);
            end
            check_value(smi, 1);
            cfg_read(8'ha4);
            check_value(d[31:29], e < 2 ? 3'h2 << e : 3'h1);
            cfg_write(8'ha4, 4'h8, 32'he0000000);
            check_value(smi, 0);
        end
        // One more rise of the semaphore, seen through the ownership support word.
        tog = 1'b1;
        tick(1);
        tog = 1'b0;
        tick(1);
        cfg_read(8'ha0);
        check_value(d, 32'h01000001);
        check_value(smi, 1);
        // A reset in mid-run must drop the enables, the flags and the request.
        cfg_write(8'ha4, 4'h3, 32'h0000c03f);
        cfg_write(8'h10, 4'hf, 32'h00001000);
        srst = 1'b1;
        tick(2);
        srst = 1'b0;
        check_value(smi, 0);
        cfg_read(8'ha4);
        check_value(d, 32'h0);
        complete_run();
    end
endmodule
`default_nettype wire
